// file: stq_qualifier.sv
// stq_qualifier.sv - recognizers and one qualifier output per analyzer
// assumes configuration is held static while sampling runs
`timescale 1ns/1ps
`include "stq_defs.svh"
module stq_qualifier
  import stq_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  sample_en,
  input  wire logic [`STQ_W-1:0]     state_in,
  input  wire logic                  dual_mode,
  input  stq_pat_t [`STQ_NREC-1:0]   pats,
  input  wire logic [`STQ_W-1:0]     rng_lo,
  input  wire logic [`STQ_W-1:0]     rng_hi,
  input  stq_qual_t                  qual_a,
  input  stq_qual_t                  qual_b,
  output logic [`STQ_NREC-1:0]       rec_hit,
  output logic                       rng_hit,
  output logic                       qual_a_hit,
  output logic                       qual_b_hit,
  output logic                       hit_valid
);
  // ------------------------------------------------------------
  // recognizers
  // ------------------------------------------------------------
  logic [`STQ_NREC-1:0] hit_c;
  logic                 rng_c;
  for (genvar i = 0; i < `STQ_NREC; i++) begin : g_rec
    stq_pat_rec u_rec (
      .state (state_in),
      .pat   (pats[i]),
      .hit   (hit_c[i])
    );
  end
  // bounds compared unsigned; bounds must be fully specified
  assign rng_c = (state_in >= rng_lo) && (state_in <= rng_hi);

  // ------------------------------------------------------------
  // qualifier select
  // ------------------------------------------------------------
  function automatic logic grp_eval(input logic [`STQ_GRP-1:0] h,
                                    input logic [`STQ_GRP-1:0] en,
                                    input logic is_and,
                                    input logic r_on,
                                    input logic r_val);
    logic any_on;
    logic v;
    any_on = (|en) | r_on;
    if (is_and) begin
      v = &(~h | ~en) & (~r_on | r_val);
    end else begin
      v = |(h & en) | (r_on & r_val);
    end
    return any_on & v;
  endfunction : grp_eval

  // base: lowest recognizer owned; lim: count owned
  function automatic logic qual_eval(input stq_qual_t q,
                                     input logic [`STQ_NREC-1:0] h,
                                     input logic r,
                                     input logic owns_rng,
                                     input logic [3:0] base,
                                     input logic [3:0] lim);
    logic [3:0] idx;
    logic       ok;
    logic       r_on;
    logic       r_val;
    logic       g0;
    logic       g1;
    idx   = {1'b0, q.sel[2:0]};
    ok    = (idx >= base) && (idx < base + lim);
    r_on  = owns_rng && (q.rng != STQ_RNG_OFF);
    r_val = (q.rng == STQ_RNG_OUT) ? ~r : r;
    g0 = grp_eval(h[3:0], q.en[3:0], q.grp_and[0], r_on, r_val);
    g1 = grp_eval(h[7:4], q.en[7:4], q.grp_and[1], 1'b0, 1'b0);
    case (q.sel[4:3])
      2'h0: begin
        if (q.sel == `STQ_SEL_ANY) begin
          return 1'b1;
        end else if (q.sel == `STQ_SEL_NONE) begin
          return 1'b0;
        end else begin
          return ok & h[q.sel[2:0] - 3'h2 + 3'h2];
        end
      end
      default: begin
        if (q.sel >= `STQ_SEL_NPAT && q.sel < `STQ_SEL_RNG) begin
          idx = {1'b0, q.sel[2:0] - 3'h2};
          ok  = (idx >= base) && (idx < base + lim);
          return ok & ~h[idx[2:0]];
        end else if (q.sel == `STQ_SEL_RNG) begin
          return owns_rng & r;
        end else if (q.sel == `STQ_SEL_NRNG) begin
          return owns_rng & ~r;
        end else if (q.sel == `STQ_SEL_COMB) begin
          if (lim == `STQ_CNT_ALL) begin
            return g0 | g1;
          end else if (base == `STQ_BASE_A) begin
            return g0;
          end else begin
            return g1;
          end
        end else begin
          return 1'b0;
        end
      end
    endcase
  endfunction : qual_eval

  // ------------------------------------------------------------
  // select decode
  // ------------------------------------------------------------
  // single pattern picks sit on codes 0x02..0x09 and take the short path
  // qual_b never sees the range: it always follows the first analyzer
  logic a_single;
  logic b_single;
  logic qa_c;
  logic qb_c;
  always_comb begin
    a_single = 1'b0;
    b_single = 1'b0;
    if (qual_a.sel >= `STQ_SEL_PAT && qual_a.sel < `STQ_SEL_NPAT) begin
      a_single = 1'b1;
    end
    if (qual_b.sel >= `STQ_SEL_PAT && qual_b.sel < `STQ_SEL_NPAT) begin
      b_single = 1'b1;
    end
  end

  function automatic logic single_eval(input stq_qual_t q,
                                       input logic [`STQ_NREC-1:0] h,
                                       input logic [3:0] base,
                                       input logic [3:0] lim);
    logic [3:0] idx;
    idx = {1'b0, 3'(q.sel - `STQ_SEL_PAT)};
    return (idx >= base) && (idx < base + lim) && h[idx[2:0]];
  endfunction : single_eval

  // analyzer a always starts at recognizer a; dual mode only halves its count
  // so a half-owned pick reads false instead of borrowing the other half
  logic [3:0] b_base;
  logic [3:0] a_lim;
  assign a_lim  = dual_mode ? `STQ_CNT_HALF : `STQ_CNT_ALL;
  assign b_base = `STQ_BASE_B;

  always_comb begin
    if (a_single) begin
      qa_c = single_eval(qual_a, hit_c, `STQ_BASE_A, a_lim);
    end else begin
      qa_c = qual_eval(qual_a, hit_c, rng_c, 1'b1, `STQ_BASE_A, a_lim);
    end
    if (!dual_mode) begin
      qb_c = 1'b0;
    end else if (b_single) begin
      qb_c = single_eval(qual_b, hit_c, b_base, `STQ_CNT_HALF);
    end else begin
      qb_c = qual_eval(qual_b, hit_c, rng_c, 1'b0, b_base, `STQ_CNT_HALF);
    end
  end

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  // one capture per sample keeps all terms coherent for the sequencer
  // recognizer hits, held between samples
  logic [`STQ_NREC-1:0] rec_d;
  logic                 rng_d;
  always_comb begin
    rec_d = rec_hit;
    rng_d = rng_hit;
    if (sample_en) begin
      rec_d = hit_c;
      rng_d = rng_c;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rec_hit <= '0;
      rng_hit <= 1'b0;
    end else begin
      rec_hit <= rec_d;
      rng_hit <= rng_d;
    end
  end

  // qualifier results, the terms the sequencer levels consume
  logic qa_d;
  logic qb_d;
  always_comb begin
    qa_d = qual_a_hit;
    qb_d = qual_b_hit;
    if (sample_en) begin
      qa_d = qa_c;
      qb_d = qb_c;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      qual_a_hit <= 1'b0;
      qual_b_hit <= 1'b0;
    end else begin
      qual_a_hit <= qa_d;
      qual_b_hit <= qb_d;
    end
  end

  // sample marker: one cycle only, so a held hit is never counted twice
  logic val_d;
  always_comb begin
    val_d = 1'b0;
    if (sample_en) begin
      val_d = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hit_valid <= 1'b0;
    end else begin
      hit_valid <= val_d;
    end
  end
endmodule : stq_qualifier

// file: stq_defs.svh
// stq_defs.svh - constants and behaviour notes for the state trigger qualifier
// assumes inclusion by bare name from the package and the design modules
// Notes on behaviour
// - pattern matches when every cared bit equals the stored bit
// - one analyzer active: all eight pattern recognizers serve it
// - two analyzers active: four pattern recognizers go to each
// - recognizers a to h form two fixed groups, a-d and e-h
// - range asserts when lower bound <= value <= upper bound
// - one range recognizer, bound to the first or only analyzer
// - qualifier: any, none, one recognizer, complement, or combination
// - per group one operator: plain terms ORed, complemented terms ANDed
// - range joins group one as off, in, or complemented
// - two analyzers: a-d plus range to first, e-h to second
`ifndef STQ_DEFS_SVH
`define STQ_DEFS_SVH
`define STQ_W        32
`define STQ_NREC     8
`define STQ_GRP      4
`define STQ_SELW     5
`define STQ_SEL_ANY  5'h00
`define STQ_SEL_NONE 5'h01
`define STQ_SEL_PAT  5'h02
`define STQ_SEL_NPAT 5'h0a
`define STQ_SEL_RNG  5'h12
`define STQ_SEL_NRNG 5'h13
`define STQ_SEL_COMB 5'h14
`define STQ_BASE_A   4'h0
`define STQ_BASE_B   4'h4
`define STQ_CNT_HALF 4'h4
`define STQ_CNT_ALL  4'h8
`endif

// file: stq_pkg.sv
// stq_pkg.sv - types shared by the qualifier modules
// assumes stq_defs.svh on the include path
`include "stq_defs.svh"
package stq_pkg;
  typedef struct packed {
    logic [`STQ_W-1:0] value;
    logic [`STQ_W-1:0] care;
  } stq_pat_t;
  typedef enum logic [1:0] {
    STQ_RNG_OFF = 2'h0,
    STQ_RNG_IN  = 2'h1,
    STQ_RNG_OUT = 2'h2
  } stq_rng_t;
  typedef struct packed {
    logic [`STQ_SELW-1:0] sel;
    logic [1:0]           grp_and;
    logic [`STQ_NREC-1:0] en;
    stq_rng_t             rng;
  } stq_qual_t;
endpackage : stq_pkg

// file: stq_pat_rec.sv
// stq_pat_rec.sv - one bit pattern recognizer
// assumes state and pattern are stable in the same cycle
`timescale 1ns/1ps
`include "stq_defs.svh"
module stq_pat_rec
  import stq_pkg::*;
(
  input  wire logic [`STQ_W-1:0] state,
  input  stq_pat_t               pat,
  output logic                   hit
);
  // don't-care bits are masked before compare
  assign hit = ((state ^ pat.value) & pat.care) == '0;
endmodule : stq_pat_rec

// file: stq_qualifier_chk.sv
// stq_qualifier_chk.sv - port assertions for stq_qualifier
// assumes the bind below; one clock, sync active-low reset
`timescale 1ns/1ps
module stq_qualifier_chk
  import stq_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        sample_en,
  input wire logic [31:0] state_in,
  input wire logic        dual_mode,
  input stq_pat_t [7:0]   pats,
  input wire logic [31:0] rng_lo,
  input wire logic [31:0] rng_hi,
  input stq_qual_t        qual_a,
  input stq_qual_t        qual_b,
  input wire logic [7:0]  rec_hit,
  input wire logic        rng_hit,
  input wire logic        qual_a_hit,
  input wire logic        qual_b_hit,
  input wire logic        hit_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  valid_pulse_a: assert property (sample_en |=> hit_valid) else $error("no valid");
  idle_hold_a: assert property (!sample_en |=> !hit_valid && $stable(rec_hit) && $stable(qual_a_hit))
    else $error("moved idle");
  pat_first_a: assert property (sample_en |=> rec_hit[0] == $past(((state_in ^ pats[0].value) & pats[0].care) == 0))
    else $error("pattern a");
  rng_bounds_a: assert property (sample_en |=> rng_hit == $past(state_in >= rng_lo && state_in <= rng_hi))
    else $error("range");
  qual_any_a: assert property (sample_en && qual_a.sel == 5'h00 |=> qual_a_hit) else $error("any");
  qual_none_a: assert property (sample_en && qual_a.sel == 5'h01 |=> !qual_a_hit) else $error("none");
  qual_nrng_a: assert property (sample_en && qual_a.sel == 5'h13 |=> qual_a_hit != rng_hit) else $error("nrng");
  single_b_off_a: assert property (sample_en && !dual_mode |=> !qual_b_hit) else $error("b on");
  b_no_range_a: assert property (sample_en && qual_b.sel == 5'h12 |=> !qual_b_hit) else $error("b range");
endmodule : stq_qualifier_chk
bind stq_qualifier stq_qualifier_chk i_chk (.*);

// file: stq_target.sv
// stq_target.sv - model of the probed target's sampled state bus
// assumes the bench calls send; clk is the sampling clock
`timescale 1ns/1ps
module stq_target (
  input  wire logic   clk,
  output logic [31:0] state,
  output logic        strobe
);
  initial {state, strobe} = '0;
  // released bus shows the inverse, so stale values never look valid
  task automatic send(input logic [31:0] v);
    @(negedge clk);
    state = v;
    strobe = 1'b1;
    @(negedge clk);
    strobe = 1'b0;
    state = ~v;
  endtask : send
endmodule : stq_target

// file: tb_top.sv
// tb_top.sv - self-checking bench for stq_qualifier
// assumes stq_target and the bound checker are compiled first
`timescale 1ns/1ps
module tb_top
  import stq_pkg::*;
;
  logic           clk = 0, rst_n = 0, se, dual = 0;
  logic [31:0]    st, lo = 32'h0a, hi = 32'h14;
  logic [7:0]     rh;
  logic           rg, ha, hb, hv;
  stq_pat_t [7:0] pats = '1;
  stq_qual_t      qa = '0, qb = '0;
  int             err_total = 0, samples_checked = 0, cyc = 0;
  always #12.5 clk = ~clk;
  stq_target i_tgt (.clk(clk), .state(st), .strobe(se));
  stq_qualifier i_dut (.clk(clk), .rst_n(rst_n), .sample_en(se), .state_in(st), .dual_mode(dual), .pats(pats),
    .rng_lo(lo), .rng_hi(hi), .qual_a(qa), .qual_b(qb), .rec_hit(rh), .rng_hit(rg), .qual_a_hit(ha),
    .qual_b_hit(hb), .hit_valid(hv));
  task automatic chk(input logic [11:0] g, e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic smp(input logic [31:0] v, input logic [10:0] e);
    i_tgt.send(v);
    chk({hv, rh, rg, ha, hb}, {1'b1, e});
    @(negedge clk) chk({hv, rh, rg, ha, hb}, {1'b0, e});
  endtask : smp
  task automatic t_sel();
    logic [4:0] sl [8] = '{5'h00, 5'h01, 5'h02, 5'h09, 5'h0a, 5'h11, 5'h12, 5'h13};
    logic [7:0] ex = 8'hb1;
    pats[0] = '{32'h85c4, 32'hffff};
    pats[7] = '{32'h1, 32'h0};
    for (int i = 0; i < 8; i++) begin
      @(negedge clk) qa.sel = sl[i];
      smp(32'habcd_85c4, {8'h81, 1'b0, ex[7-i], 1'b0});
    end
    smp(32'h85c5, {8'h80, 3'b010});
  endtask : t_sel
  task automatic t_rng();
    logic [31:0] v [4] = '{32'h09, 32'h0a, 32'h14, 32'h15};
    for (int i = 0; i < 4; i++) smp(v[i], {8'h80, i[0] ^ i[1], !(i[0] ^ i[1]), 1'b0});
  endtask : t_rng
  task automatic t_comb();
    @(negedge clk);
    dual = 1'b1;
    for (int i = 0; i < 8; i++) pats[i] = '{i, 32'hffff_ffff};
    qa = '{5'h14, 2'h0, 8'h0e, STQ_RNG_IN};
    qb = '{5'h14, 2'h2, 8'h50, STQ_RNG_OFF};
    smp(32'h2, {8'h04, 3'b011});
    smp(32'h4, {8'h10, 3'b000});
    smp(32'hf, {8'h00, 3'b111});
    smp(32'h0, {8'h01, 3'b001});
    @(negedge clk) qa.rng = STQ_RNG_OUT;
    smp(32'hf, {8'h00, 3'b101});
    @(negedge clk) {qa.sel, qb.sel} = {5'h06, 5'h06};
    smp(32'h4, {8'h10, 3'b001});
  endtask : t_comb
  task automatic t_own();
    @(negedge clk) {qa.sel, qb.sel} = {5'h14, 5'h12};
    smp(32'hf, {8'h00, 3'b100});
    @(negedge clk) qb.sel = 5'h0a;
    smp(32'h1, {8'h02, 3'b010});
    @(negedge clk) begin
      dual = 1'b0;
      qa.en = 8'h50;
      qa.grp_and = 2'h2;
      qa.rng = STQ_RNG_OFF;
    end
    smp(32'h1, {8'h02, 3'b010});
    smp(32'h6, {8'h40, 3'b000});
  endtask : t_own
  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    chk({hv, rh, rg, ha, hb}, 12'h0);
    t_sel();
    t_rng();
    t_comb();
    t_own();
    wrap_up();
  end
endmodule : tb_top
